// File: common/cal_seq_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef CAL_SEQ_CONSTS_SVH
`define CAL_SEQ_CONSTS_SVH
`define OFS_CAL_CTRL      10'h016
`define OFS_SEQ_STAT      10'h017
`define OFS_SYN_CTRL      10'h018
`define OFS_BBPLL_DIV     10'h019
`define OFS_CP_START      10'h01A
`define OFS_BBPLL_STAT    10'h05E
`define OFS_RX_INT_WORD   10'h231
`define OFS_RX_CP_STAT    10'h244
`define OFS_RX_LOCK_STAT  10'h247
`define OFS_TX_INT_WORD   10'h271
`define OFS_TX_CP_STAT    10'h284
`define OFS_TX_LOCK_STAT  10'h287
`define BIT_BB_DC         0
`define BIT_RF_DC         1
`define BIT_RX_QUAD       2
`define BIT_TX_MON        3
`define BIT_TX_QUAD       4
`define BIT_GAIN_STEP     5
`define BIT_TX_FILT       6
`define BIT_RX_FILT       7
`define SEQ_BITS_MASK     8'h3F
`define BIT_BBPLL_LOCK    7
`define BIT_CP_DONE       7
`define BIT_SYN_LOCK      1
`define BIT_TDD_MODE      0
`define BIT_VCO_MASK      1
`define FLD_VCO_LEN_LSB   2
`define FLD_VCO_LEN_MSB   4
`define CAL_CTRL_RST      8'h00
`define SYN_CTRL_RST      8'h00
`define BBPLL_DIV_RST     4'h1
`define VCO_STEPS         20'h00009
`define VCO_STEP_BASE     20'h0000C
`define VCO_ALC_WAIT      20'h00028
`define VCO_EXP_BASE      5'h07
`define CP_CAL_CYCLES     36864
`define BBPLL_CAL_PERIODS 3456
`define SEQ_STEP_CYCLES   64
`define FILT_CAL_CYCLES   64
`endif

// File: common/cal_seq_pkg.sv
// Types shared by the calibration sequencer
package cal_seq_pkg;
    typedef enum logic [3:0] {
        S_WAIT, S_DONE, S_BBDC, S_RFDC, S_TXQ1, S_TXQ2,
        S_RXQ1, S_RXQ2, S_TXMON, S_GAIN, S_FLUSH
    } seq_e;
    typedef logic [19:0] cnt_t;
    typedef struct packed {
        logic [9:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_s;
endpackage

// File: hw/calibration_sequencer.sv
// Calibration sequencer, synthesizer calibrations and their registers
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "cal_seq_consts.svh"
module calibration_sequencer
    import cal_seq_pkg::*;
#(
    parameter int CP_CAL_CYCLES     = `CP_CAL_CYCLES,
    parameter int BBPLL_CAL_PERIODS = `BBPLL_CAL_PERIODS,
    parameter int SEQ_STEP_CYCLES   = `SEQ_STEP_CYCLES,
    parameter int FILT_CAL_CYCLES   = `FILT_CAL_CYCLES
) (
    input  wire logic       I_CORE_CLK,
    input  wire logic       I_RST_N,
    input  wire logic [9:0] I_ADDR,
    input  wire logic [7:0] I_WDATA,
    input  wire logic       I_WR,
    input  wire logic       I_RD,
    input  wire logic       I_DIRECTION_SELECT,
    output logic      [7:0] O_RDATA,
    output logic      [3:0] O_SEQ_STATE,
    output logic            O_RX_SYNTH_EN,
    output logic            O_TX_SYNTH_EN,
    output logic            O_RX_LOCK,
    output logic            O_TX_LOCK,
    output logic            O_BBPLL_LOCK
);
    logic       rst_s1_q;
    logic       rst_n;
    reg_req_s   req;
    logic [7:0] ctrl_q;
    logic [7:0] ctrl_d;
    logic [7:0] syn_q;
    logic [3:0] bb_div_q;
    seq_e       seq_q;
    seq_e       seq_d;
    cnt_t       step_q;
    cnt_t       step_d;
    logic [7:0] done_clr;
    logic [7:0] pend;
    logic       seq_busy;
    logic [3:0] code_q;
    logic       filt_busy_q;
    logic       filt_rx_q;
    cnt_t       filt_cnt_q;
    logic [7:0] filt_clr;
    logic       filt_go;
    logic [2:0] dir_s_q;
    logic       dir_q;
    logic       dir_d;
    logic       dir_rise;
    logic       dir_fall;
    logic       tdd;
    logic       vco_mask;
    cnt_t       vco_len;
    logic       bb_lock_q;
    logic       bb_busy_q;
    cnt_t       bb_cnt_q;
    logic       en_q      [2];
    logic       lock_q    [2];
    logic       vco_busy_q[2];
    cnt_t       vco_cnt_q [2];
    logic       cp_busy_q [2];
    logic       cp_done_q [2];
    cnt_t       cp_cnt_q  [2];
    logic       trig      [2];
    logic       en_d      [2];
    logic [7:0] rdata_q;

    function automatic logic [3:0] seq_code(seq_e s);
        case (s)
            S_WAIT:  seq_code = 4'h0;
            S_DONE:  seq_code = 4'h1;
            S_BBDC:  seq_code = 4'h2;
            S_RFDC:  seq_code = 4'h3;
            S_TXQ1:  seq_code = 4'h4;
            S_TXQ2:  seq_code = 4'h5;
            S_RXQ1:  seq_code = 4'h6;
            S_RXQ2:  seq_code = 4'h7;
            S_TXMON: seq_code = 4'h8;
            S_GAIN:  seq_code = 4'h9;
            default: seq_code = 4'hA;
        endcase
    endfunction

    // Position in the fixed order, zero outside the steps
    function automatic int seq_pos(seq_e s);
        int p;
        p = 0;
        if (s != S_WAIT && s != S_DONE && s != S_FLUSH) begin
            p = int'(seq_code(s)) - 1;
        end
        return p;
    endfunction

    function automatic seq_e state_at(int p);
        case (p)
            1:       state_at = S_BBDC;
            2:       state_at = S_RFDC;
            3:       state_at = S_TXQ1;
            4:       state_at = S_TXQ2;
            5:       state_at = S_RXQ1;
            6:       state_at = S_RXQ2;
            7:       state_at = S_TXMON;
            default: state_at = S_GAIN;
        endcase
    endfunction

    function automatic int bit_at(int p);
        case (p)
            1:       bit_at = `BIT_BB_DC;
            2:       bit_at = `BIT_RF_DC;
            3, 4:    bit_at = `BIT_TX_QUAD;
            5, 6:    bit_at = `BIT_RX_QUAD;
            7:       bit_at = `BIT_TX_MON;
            default: bit_at = `BIT_GAIN_STEP;
        endcase
    endfunction

    // First requested step after the current one
    function automatic seq_e seq_after(seq_e cur, logic [7:0] b);
        int p;
        seq_after = S_FLUSH;
        for (p = 8; p >= 1; p--) begin
            if (p > seq_pos(cur) && b[bit_at(p)]) begin
                seq_after = state_at(p);
            end
        end
    endfunction

    // Quadrature bits clear only after their second step
    function automatic logic [7:0] clr_mask(seq_e s);
        clr_mask = 8'h00;
        if (s != S_TXQ1 && s != S_RXQ1 && seq_pos(s) != 0) begin
            clr_mask[bit_at(seq_pos(s))] = 1'b1;
        end
    endfunction

    function automatic logic hit(reg_req_s r, logic [9:0] a);
        hit = r.wr && r.addr == a;
    endfunction

    always_ff @(posedge I_CORE_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rst_s1_q <= 1'b0;
            rst_n    <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n    <= rst_s1_q;
        end
    end

    assign req = '{addr: I_ADDR, wdata: I_WDATA, wr: I_WR, rd: I_RD};
    assign tdd      = syn_q[`BIT_TDD_MODE];
    assign vco_mask = syn_q[`BIT_VCO_MASK];
    assign pend     = ctrl_q & `SEQ_BITS_MASK;
    assign seq_busy = seq_q != S_WAIT && seq_q != S_DONE;

    // Direction pin: third stage must agree before a change counts
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            dir_s_q <= 3'h0;
            dir_q   <= 1'b0;
        end else begin
            dir_s_q <= {dir_s_q[1:0], I_DIRECTION_SELECT};
            dir_q   <= dir_d;
        end
    end
    assign dir_d    = (dir_s_q[1] == dir_s_q[2]) ? dir_s_q[2] : dir_q;
    assign dir_rise = !dir_q && dir_d;
    assign dir_fall = dir_q && !dir_d;

    // Idle until a start bit, then walk the order
    always_comb begin
        seq_d    = seq_q;
        step_d   = step_q;
        done_clr = 8'h00;
        case (seq_q)
            S_WAIT, S_DONE: begin
                if (|pend && !filt_busy_q) begin
                    seq_d  = seq_after(seq_q, pend);
                    step_d = cnt_t'(SEQ_STEP_CYCLES);
                end
            end
            S_FLUSH: seq_d = S_DONE;
            default: begin
                if (step_q == cnt_t'(1)) begin
                    done_clr = clr_mask(seq_q);
                    seq_d    = seq_after(seq_q, pend & ~done_clr);
                    step_d   = cnt_t'(SEQ_STEP_CYCLES);
                end else begin
                    step_d = step_q - cnt_t'(1);
                end
            end
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            seq_q  <= S_WAIT;
            step_q <= '0;
            code_q <= 4'h0;
        end else begin
            seq_q  <= seq_d;
            step_q <= step_d;
            code_q <= seq_code(seq_d);
        end
    end

    // Filter tuning waits for an idle sequencer
    assign filt_go = !seq_busy && pend == 8'h00 && !filt_busy_q &&
                     (ctrl_q[`BIT_RX_FILT] || ctrl_q[`BIT_TX_FILT]);
    always_comb begin
        filt_clr = 8'h00;
        if (filt_busy_q && filt_cnt_q == cnt_t'(1)) begin
            filt_clr[filt_rx_q ? `BIT_RX_FILT : `BIT_TX_FILT] = 1'b1;
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            filt_busy_q <= 1'b0;
            filt_rx_q   <= 1'b0;
            filt_cnt_q  <= '0;
        end else if (filt_go) begin
            filt_busy_q <= 1'b1;
            filt_rx_q   <= ctrl_q[`BIT_RX_FILT];
            filt_cnt_q  <= cnt_t'(FILT_CAL_CYCLES);
        end else if (filt_busy_q) begin
            filt_busy_q <= filt_cnt_q != cnt_t'(1);
            filt_cnt_q  <= filt_cnt_q - cnt_t'(1);
        end
    end

    // A new start bit wins over a same-cycle completion
    always_comb begin
        ctrl_d = ctrl_q & ~done_clr & ~filt_clr;
        if (hit(req, `OFS_CAL_CTRL)) begin
            ctrl_d = ctrl_d | req.wdata;
        end
    end

    // Reset loads defaults; ctrl_q start bits also clear when their steps end
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q   <= `CAL_CTRL_RST;
            syn_q    <= `SYN_CTRL_RST;
            bb_div_q <= `BBPLL_DIV_RST;
        end else begin
            ctrl_q <= ctrl_d;
            if (hit(req, `OFS_SYN_CTRL)) begin
                syn_q <= {3'h0, req.wdata[4:0]};
            end
            if (hit(req, `OFS_BBPLL_DIV)) begin
                bb_div_q <= req.wdata[3:0];
            end
        end
    end

    // Divide setting of zero is treated as one
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            bb_busy_q <= 1'b0;
            bb_lock_q <= 1'b0;
            bb_cnt_q  <= '0;
        end else if (hit(req, `OFS_BBPLL_DIV)) begin
            // Frequency change drops lock and recalibrates
            bb_busy_q <= 1'b1;
            bb_lock_q <= 1'b0;
            bb_cnt_q  <= cnt_t'(BBPLL_CAL_PERIODS) *
                         ((req.wdata[3:0] == 4'h0) ? cnt_t'(1)
                                                   : {16'h0000,
                                                      req.wdata[3:0]});
        end else if (bb_busy_q) begin
            bb_busy_q <= bb_cnt_q != cnt_t'(1);
            bb_lock_q <= bb_cnt_q == cnt_t'(1);
            bb_cnt_q  <= bb_cnt_q - cnt_t'(1);
        end
    end

    // Nine steps of base plus power term plus settling
    assign vco_len = `VCO_STEPS * (`VCO_STEP_BASE + `VCO_ALC_WAIT +
        (20'h00001 << (`VCO_EXP_BASE +
        {2'h0, syn_q[`FLD_VCO_LEN_MSB:`FLD_VCO_LEN_LSB]})));

    for (genvar i = 0; i < 2; i++) begin : g_synth
        localparam logic [9:0] INT_OFS = (i == 0) ? `OFS_RX_INT_WORD
                                                  : `OFS_TX_INT_WORD;
        // Integer word write or TDD direction edge
        assign trig[i] = hit(req, INT_OFS) ||
                         (tdd && ((i == 0) ? dir_fall : dir_rise));
        // Receive on low, transmit on high in TDD
        assign en_d[i] = !tdd || (dir_d == (i == 1));

        always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
            if (!rst_n) begin
                en_q[i]       <= 1'b0;
                lock_q[i]     <= 1'b0;
                vco_busy_q[i] <= 1'b0;
                vco_cnt_q[i]  <= '0;
            end else begin
                en_q[i] <= en_d[i];
                if (trig[i] && !vco_mask) begin
                    vco_busy_q[i] <= 1'b1;
                    vco_cnt_q[i]  <= vco_len;
                    lock_q[i]     <= 1'b0;
                end else if (vco_busy_q[i]) begin
                    vco_busy_q[i] <= vco_cnt_q[i] != cnt_t'(1);
                    vco_cnt_q[i]  <= vco_cnt_q[i] - cnt_t'(1);
                    // Lock once calibration ends, if enabled
                    lock_q[i] <= vco_cnt_q[i] == cnt_t'(1) && en_d[i];
                end else if (trig[i]) begin
                    lock_q[i] <= en_d[i];
                end else if (!en_d[i]) begin
                    lock_q[i] <= 1'b0;
                end
            end
        end

        always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
            if (!rst_n) begin
                cp_busy_q[i] <= 1'b0;
                cp_done_q[i] <= 1'b0;
                cp_cnt_q[i]  <= '0;
            end else if (hit(req, `OFS_CP_START) && req.wdata[i]) begin
                cp_busy_q[i] <= 1'b1;
                cp_done_q[i] <= 1'b0;
                cp_cnt_q[i]  <= cnt_t'(CP_CAL_CYCLES);
            end else if (cp_busy_q[i]) begin
                cp_busy_q[i] <= cp_cnt_q[i] != cnt_t'(1);
                cp_done_q[i] <= cp_cnt_q[i] == cnt_t'(1);
                cp_cnt_q[i]  <= cp_cnt_q[i] - cnt_t'(1);
            end
        end
    end

    // Status bits sit at their bit positions
    always_ff @(posedge I_CORE_CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (req.rd) begin
            case (req.addr)
                `OFS_CAL_CTRL:     rdata_q <= ctrl_q;
                `OFS_SEQ_STAT:     rdata_q <= {4'h0, code_q};
                `OFS_SYN_CTRL:     rdata_q <= syn_q;
                `OFS_BBPLL_DIV:    rdata_q <= {4'h0, bb_div_q};
                `OFS_CP_START:     rdata_q <= {6'h00, cp_busy_q[1],
                                               cp_busy_q[0]};
                `OFS_BBPLL_STAT:   rdata_q <= {bb_lock_q, 7'h00};
                `OFS_RX_CP_STAT:   rdata_q <= {cp_done_q[0], 7'h00};
                `OFS_TX_CP_STAT:   rdata_q <= {cp_done_q[1], 7'h00};
                `OFS_RX_LOCK_STAT: rdata_q <= {6'h00, lock_q[0], 1'b0};
                `OFS_TX_LOCK_STAT: rdata_q <= {6'h00, lock_q[1], 1'b0};
                default:           rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign O_RDATA       = rdata_q;
    assign O_SEQ_STATE   = code_q;
    assign O_RX_SYNTH_EN = en_q[0];
    assign O_TX_SYNTH_EN = en_q[1];
    assign O_RX_LOCK     = lock_q[0];
    assign O_TX_LOCK     = lock_q[1];
    assign O_BBPLL_LOCK  = bb_lock_q;

    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!rst_n);

    AST_SEQ_DONE: assert property (
        seq_q == S_FLUSH |=> seq_q == S_DONE && code_q == 4'h1)
        else $error("done code missing after flush");
    AST_SEQ_CODE: assert property (
        seq_q == S_TXMON |=> code_q == 4'h8 || $past(step_q) == 1)
        else $error("monitor step code wrong");
    AST_SEQ_ORDER: assert property (
        seq_q == S_BBDC && step_q == 1 && ctrl_q[1] |=> seq_q == S_RFDC)
        else $error("steps out of order");
    AST_SELF_CLEAR: assert property (
        seq_q == S_RFDC && step_q == 1 && !hit(req, `OFS_CAL_CTRL)
        |=> !ctrl_q[1])
        else $error("start bit did not clear");
    AST_FILT_EXCL: assert property (
        filt_busy_q |-> !seq_busy)
        else $error("filter tuning during sequence");
    AST_FILT_CLEAR: assert property (
        filt_busy_q && filt_rx_q && filt_cnt_q == 1 &&
        !hit(req, `OFS_CAL_CTRL) |=> !ctrl_q[7] && !filt_busy_q)
        else $error("receive tuning bit stuck");
    AST_BB_RELOCK: assert property (
        hit(req, `OFS_BBPLL_DIV) |=> !bb_lock_q && bb_busy_q)
        else $error("pll change kept lock");
    AST_CP_BOUND: assert property (
        cp_busy_q[0] && cp_cnt_q[0] == cnt_t'(1) &&
        !hit(req, `OFS_CP_START) |=> cp_done_q[0] && !cp_busy_q[0])
        else $error("charge pump over length");
    AST_INT_TRIG: assert property (
        hit(req, `OFS_RX_INT_WORD) && !vco_mask
        |=> vco_busy_q[0] && !O_RX_LOCK)
        else $error("integer write did not calibrate");
    AST_TDD_EN: assert property (
        tdd && dir_d |=> !O_RX_SYNTH_EN && O_TX_SYNTH_EN)
        else $error("wrong synthesizer enabled");
    AST_TDD_RISE: assert property (
        tdd && dir_rise && !vco_mask |=> vco_busy_q[1])
        else $error("rising edge missed transmit cal");
    AST_MASK: assert property (
        vco_mask && !vco_busy_q[0] |=> !vco_busy_q[0])
        else $error("masked calibration ran");
    AST_VCO_LEN: assert property (
        trig[1] && !vco_mask |=> vco_cnt_q[1] == $past(vco_len))
        else $error("calibration length wrong");

    COV_FULL_SEQ: cover property (seq_q == S_GAIN ##1 seq_q == S_FLUSH);
    COV_FILT: cover property (filt_busy_q && !filt_rx_q);
    COV_CP: cover property ($rose(cp_done_q[1]));
    COV_TDD_LOCK: cover property (tdd && $rose(O_TX_LOCK));
endmodule

// File: dv/bbp_host_model.sv
// Behavioural register master standing in for the baseband processor
`timescale 1ns/1ps
module bbp_host_model
    import cal_seq_pkg::*;
(
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rdata,
    output reg_req_s        o_req
);
    initial begin
        o_req = '0;
    end

    // Strobes last one cycle; a new request waits for the next edge
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge i_clk);
        o_req.wr <= 1'b0;
    endtask

    // Read data stands only in the cycle after the strobe edge
    task automatic rd(input logic [9:0] a, output logic [7:0] d);
        @(posedge i_clk);
        o_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge i_clk);
        o_req.rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask
endmodule

// File: dv/calibration_sequencer_tb.sv
// Self-checking testbench for the calibration sequencer
`timescale 1ns/1ps
`include "cal_seq_consts.svh"
module calibration_sequencer_tb;
    import cal_seq_pkg::*;
    logic       clk;
    logic       rst_n;
    logic       dir;
    reg_req_s   req;
    logic [7:0] rdata;
    logic [3:0] seq_state;
    logic       rx_en, tx_en, rx_lock, tx_lock, bb_lock;
    int         errors;
    int         checks_done;
    logic [7:0] v;

    initial clk = 1'b0;
    always #5 clk = ~clk;

    calibration_sequencer #(
        .CP_CAL_CYCLES(50), .BBPLL_CAL_PERIODS(4),
        .SEQ_STEP_CYCLES(4), .FILT_CAL_CYCLES(4)
    ) calibration_sequencer_inst (
        .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_ADDR(req.addr),
        .I_WDATA(req.wdata), .I_WR(req.wr), .I_RD(req.rd),
        .I_DIRECTION_SELECT(dir), .O_RDATA(rdata),
        .O_SEQ_STATE(seq_state), .O_RX_SYNTH_EN(rx_en),
        .O_TX_SYNTH_EN(tx_en), .O_RX_LOCK(rx_lock),
        .O_TX_LOCK(tx_lock), .O_BBPLL_LOCK(bb_lock)
    );

    bbp_host_model bbp_host_model_inst (
        .i_clk(clk), .i_rdata(rdata), .o_req(req)
    );

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic rchk(input logic [9:0] a, input logic [7:0] exp);
        logic [7:0] d;
        bbp_host_model_inst.rd(a, d);
        chk({24'h0, d}, {24'h0, exp});
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    function automatic logic pick(input int s);
        return (s == 0) ? rx_lock : (s == 1) ? tx_lock : bb_lock;
    endfunction

    // Counts cycles until the chosen lock rises; window is lo..hi
    task automatic wait_lock(input int s, input int lo, input int hi);
        int n;
        n = 0;
        while (pick(s) !== 1'b1 && n <= hi) begin
            cyc(1);
            n++;
        end
        chk({31'h0, n >= lo && n <= hi}, 32'h1);
    endtask

    // Collects every state code shown until the done code appears
    task automatic run_seq(input logic [7:0] bits, input logic [31:0] exp);
        logic [31:0] got;
        logic [3:0]  last;
        int          n;
        got = '0;
        last = seq_state;
        n = 0;
        bbp_host_model_inst.wr(`OFS_CAL_CTRL, bits);
        while (n < 200 && !(got != 0 && last === 4'h1)) begin
            cyc(1);
            n++;
            if (seq_state !== last) begin
                got = {got[27:0], seq_state};
                last = seq_state;
            end
        end
        chk(got, exp);
    endtask

    task automatic close_out;
        $display("Checks %0d, mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        close_out();
    end

    initial begin
        errors = 0;
        checks_done = 0;
        rst_n = 1'b0;
        dir = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        cyc(4);
        rchk(`OFS_CAL_CTRL, 8'h00);
        rchk(`OFS_SEQ_STAT, 8'h00);
        rchk(10'h3FF, 8'h00);
        chk({30'h0, rx_en, tx_en}, 32'h3);
        $display("Test reset done");
        // Charge pump first, in FDD as advises
        bbp_host_model_inst.wr(`OFS_CP_START, 8'h03);
        rchk(`OFS_RX_CP_STAT, 8'h00);
        cyc(52);
        rchk(`OFS_RX_CP_STAT, 8'h80);
        rchk(`OFS_TX_CP_STAT, 8'h80);
        $display("Test charge pump done");
        bbp_host_model_inst.wr(`OFS_BBPLL_DIV, 8'h02);
        cyc(1);
        chk({31'h0, bb_lock}, 32'h0);
        wait_lock(2, 5, 9);
        rchk(`OFS_BBPLL_STAT, 8'h80);
        $display("Test baseband pll done");
        bbp_host_model_inst.wr(10'h3FF, 8'hFF);
        bbp_host_model_inst.wr(`OFS_CAL_CTRL, 8'hC0);
        cyc(20);
        chk({28'h0, seq_state}, 32'h0);
        rchk(`OFS_CAL_CTRL, 8'h00);
        $display("Test filter tuning done");
        // RF DC and quadrature rerun as after a large LO move
        run_seq(8'h13, 32'h002345A1);
        rchk(`OFS_CAL_CTRL, 8'h00);
        rchk(`OFS_SEQ_STAT, 8'h01);
        run_seq(8'h2C, 32'h006789A1);
        rchk(`OFS_CAL_CTRL, 8'h00);
        $display("Test sequencer done");
        // Setup written before the integer word
        bbp_host_model_inst.wr(`OFS_SYN_CTRL, 8'h00);
        bbp_host_model_inst.wr(`OFS_RX_INT_WORD, 8'h40);
        cyc(1);
        chk({31'h0, rx_lock}, 32'h0);
        wait_lock(0, 1605, 1630);
        rchk(`OFS_RX_LOCK_STAT, 8'h02);
        bbp_host_model_inst.wr(`OFS_SYN_CTRL, 8'h02);
        bbp_host_model_inst.wr(`OFS_TX_INT_WORD, 8'h40);
        wait_lock(1, 0, 4);
        rchk(`OFS_TX_LOCK_STAT, 8'h02);
        $display("Test vco calibration done");
        bbp_host_model_inst.wr(`OFS_SYN_CTRL, 8'h01);
        cyc(8);
        chk({30'h0, rx_en, tx_en}, 32'h2);
        dir <= 1'b1;
        cyc(8);
        chk({29'h0, rx_en, tx_en, tx_lock}, 32'h2);
        wait_lock(1, 1595, 1630);
        dir <= 1'b0;
        cyc(8);
        chk({29'h0, rx_en, tx_en, rx_lock}, 32'h4);
        wait_lock(0, 1595, 1630);
        $display("Test tdd done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        cyc(4);
        rchk(`OFS_RX_CP_STAT, 8'h00);
        chk({31'h0, rx_lock}, 32'h0);
        $display("Test hard reset done");
        close_out();
    end
endmodule
